// file: src/dbnsc_pkg.sv
// Purpose: constants for the down-conversion routing and nco_phase_sync_control control block
// Assumes: one device clock, plain register port with 12-bit address
// Notes:
// How it works
// - path b routing bit picks converter a/b
// - path a routing bit picks converter a/b
// - routing register resets to 0x02
// - path powers down with its source converter
// - 16-bit rational divisor cancels frequency error
// - one divisor shared by all presets
// - ila bit selects lmfc phase init
// - sync register resets to 0x02
// - arm bit written 0 then 1 arms
// - later sysref edges ignored until rearmed
// - first sysref rising edge after arm initialises
package dbnsc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_ROUTING = 12'h216;
    localparam logic [11:0] ADDR_RDIV_LO = 12'h217;
    localparam logic [11:0] ADDR_RDIV_HI = 12'h218;
    localparam logic [11:0] ADDR_SYNC = 12'h219;
    localparam logic [7:0] ROUTING_RST = 8'h02;
    localparam logic [15:0] RDIV_RST = 16'h0000;
    localparam logic [7:0] SYNC_RST = 8'h02;
    localparam int BIT_PATH_A_SEL = 0;
    localparam int BIT_PATH_B_SEL = 1;
    localparam int BIT_SYNC_NEXT = 0;
    localparam int BIT_SYNC_ILA = 1;
    typedef enum logic [1:0] {
        DBNSC_IDLE = 2'b00,
        DBNSC_PRIMED = 2'b01,
        DBNSC_ARMED = 2'b10
    } dbnsc_arm_t;
endpackage

// file: src/dbnsc_sync2.sv
`timescale 1ns/1ps
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to ref_clk
// Notes: first stage feeds only the second
module dbnsc_sync2 (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // dbnsc_sync2

// file: src/dbnsc_ctrl.sv
`timescale 1ns/1ps
// Purpose: channel routing, path power-down, rational divisor and nco phase sync control
// Assumes: sysref arrives as an asynchronous pin; lmfc ila start is a same-clock pulse
// Notes: read data valid one cycle after the read strobe only
module dbnsc_ctrl
    import dbnsc_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [SAMPLE_W-1:0] conv_a_data,
    input wire logic [SAMPLE_W-1:0] conv_b_data,
    input wire logic converter_a_powerdown,
    input wire logic converter_b_powerdown,
    input wire logic sysref_pin,
    input wire logic lmfc_ila_start,
    output logic [SAMPLE_W-1:0] path_a_data,
    output logic [SAMPLE_W-1:0] path_b_data,
    output logic path_a_powerdown,
    output logic path_b_powerdown,
    output logic [15:0] rational_nco_divisor,
    output logic nco_phase_init,
    output logic sync_armed
);
    logic [7:0] routing_q;
    logic [15:0] rdiv_q;
    logic [7:0] sync_q;
    dbnsc_arm_t arm_q;
    dbnsc_arm_t arm_d;
    logic sysref_s;
    logic sysref_prev_q;
    logic sysref_rise;
    logic wr_sync;
    logic next_wr_val;

    function automatic logic pick_pd(input logic sel, input logic pd_a, input logic pd_b);
        pick_pd = sel ? pd_b : pd_a;
    endfunction

    // register writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            routing_q <= ROUTING_RST;
            rdiv_q <= RDIV_RST;
            sync_q <= SYNC_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_ROUTING: routing_q <= reg_wdata;
                ADDR_RDIV_LO: rdiv_q[7:0] <= reg_wdata;
                ADDR_RDIV_HI: rdiv_q[15:8] <= reg_wdata;
                ADDR_SYNC: sync_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read port, unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_ROUTING: reg_rdata <= routing_q;
                ADDR_RDIV_LO: reg_rdata <= rdiv_q[7:0];
                ADDR_RDIV_HI: reg_rdata <= rdiv_q[15:8];
                ADDR_SYNC: reg_rdata <= sync_q;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // sample routing and derived power-down
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            path_a_data <= '0;
            path_b_data <= '0;
            path_a_powerdown <= 1'b0;
            path_b_powerdown <= 1'b0;
        end else begin
            path_a_data <= routing_q[BIT_PATH_A_SEL] ? conv_b_data : conv_a_data;
            path_b_data <= routing_q[BIT_PATH_B_SEL] ? conv_b_data : conv_a_data;
            path_a_powerdown <= pick_pd(routing_q[BIT_PATH_A_SEL], converter_a_powerdown,
                converter_b_powerdown);
            path_b_powerdown <= pick_pd(routing_q[BIT_PATH_B_SEL], converter_a_powerdown,
                converter_b_powerdown);
        end
    end

    // one divisor for all presets of both paths
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rational_nco_divisor <= RDIV_RST;
        end else begin
            rational_nco_divisor <= rdiv_q;
        end
    end

    dbnsc_sync2 u_sysref_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(sysref_pin),
        .sync_out(sysref_s)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sysref_prev_q <= 1'b0;
        end else begin
            sysref_prev_q <= sysref_s;
        end
    end
    assign sysref_rise = sysref_s & ~sysref_prev_q;

    assign wr_sync = reg_wr && (reg_addr == ADDR_SYNC);
    assign next_wr_val = reg_wdata[BIT_SYNC_NEXT];

    // arm sequence: a 0 write primes, then a 1 write arms
    always_comb begin
        arm_d = arm_q;
        unique case (arm_q)
            DBNSC_IDLE: begin
                if (wr_sync && !next_wr_val) begin
                    arm_d = DBNSC_PRIMED;
                end
            end
            DBNSC_PRIMED: begin
                if (wr_sync && next_wr_val) begin
                    arm_d = DBNSC_ARMED;
                end
            end
            DBNSC_ARMED: begin
                if (wr_sync && !next_wr_val) begin
                    arm_d = DBNSC_PRIMED;
                end else if (sysref_rise) begin
                    arm_d = DBNSC_IDLE;
                end
            end
            default: arm_d = DBNSC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            arm_q <= DBNSC_IDLE;
        end else begin
            arm_q <= arm_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nco_phase_init <= 1'b0;
            sync_armed <= 1'b0;
        end else begin
            nco_phase_init <= (arm_q == DBNSC_ARMED && sysref_rise)
                || (sync_q[BIT_SYNC_ILA] && lmfc_ila_start);
            sync_armed <= (arm_d == DBNSC_ARMED);
        end
    end

    a_route_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> path_b_data == ($past(routing_q[BIT_PATH_B_SEL]) ? $past(conv_b_data)
            : $past(conv_a_data))) else $error("path b routing wrong");
    a_route_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> path_a_data == ($past(routing_q[BIT_PATH_A_SEL]) ? $past(conv_b_data)
            : $past(conv_a_data))) else $error("path a routing wrong");
    a_route_reset: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> routing_q == ROUTING_RST) else $error("routing reset value wrong");
    a_pd_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> path_a_powerdown == ($past(routing_q[BIT_PATH_A_SEL]) ?
            $past(converter_b_powerdown) : $past(converter_a_powerdown))) else $error("path a pd wrong");
    a_rdiv_shared: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> rational_nco_divisor == $past(rdiv_q)) else $error("divisor not shared");
    a_ila_init: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sync_q[BIT_SYNC_ILA] && lmfc_ila_start |=> nco_phase_init) else $error("ila init missed");
    a_sync_reset: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> sync_q == SYNC_RST) else $error("sync reset value wrong");
    a_arm_seq: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q == DBNSC_PRIMED && wr_sync && next_wr_val |=> sync_armed) else $error("arm failed");
    a_one_shot: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q != DBNSC_ARMED && sysref_rise && !(sync_q[BIT_SYNC_ILA] && lmfc_ila_start)
            |=> !nco_phase_init) else $error("rearm needed");
    a_sysref_init: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(sysref_pin) && arm_q == DBNSC_ARMED && !reg_wr ##1 !reg_wr ##1 !reg_wr
            |-> ##[1:2] nco_phase_init) else $error("sysref init missed");

    // path b power-down mirrors its source converter
    a_pd_route_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> path_b_powerdown == ($past(routing_q[BIT_PATH_B_SEL]) ?
            $past(converter_b_powerdown) : $past(converter_a_powerdown)))
        else $error("path b pd wrong");

    // outputs and registers straight after reset
    a_rst_outputs: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> !sync_armed && !nco_phase_init && reg_rdata == 8'h00
            && rational_nco_divisor == RDIV_RST)
        else $error("outputs not cleared by reset");

    a_rdiv_reset: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> rdiv_q == RDIV_RST)
        else $error("divisor reset value wrong");

    a_path_reset: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> !path_a_powerdown && !path_b_powerdown && path_a_data == '0 && path_b_data == '0)
        else $error("path outputs not cleared by reset");

    // read port: data only in the cycle after the strobe
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    a_rd_routing: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(reg_rd) && $past(reg_addr) == ADDR_ROUTING
            |-> reg_rdata == $past(routing_q))
        else $error("routing read back wrong");

    a_rd_rdiv_lo: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(reg_rd) && $past(reg_addr) == ADDR_RDIV_LO
            |-> reg_rdata == $past(rdiv_q[7:0]))
        else $error("divisor low read back wrong");

    a_rd_rdiv_hi: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(reg_rd) && $past(reg_addr) == ADDR_RDIV_HI
            |-> reg_rdata == $past(rdiv_q[15:8]))
        else $error("divisor high read back wrong");

    a_rd_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(reg_rd) && $past(reg_addr) == ADDR_SYNC
            |-> reg_rdata == $past(sync_q))
        else $error("sync read back wrong");

    // register writes land one cycle later
    a_wr_routing: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == ADDR_ROUTING |=> routing_q == $past(reg_wdata))
        else $error("routing write lost");

    a_wr_rdiv_lo: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == ADDR_RDIV_LO |=> rdiv_q[7:0] == $past(reg_wdata))
        else $error("divisor low write lost");

    a_wr_rdiv_hi: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == ADDR_RDIV_HI |=> rdiv_q[15:8] == $past(reg_wdata))
        else $error("divisor high write lost");

    a_wr_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_sync |=> sync_q == $past(reg_wdata))
        else $error("sync write lost");

    // arm sequencing
    a_arm_prime: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (arm_q == DBNSC_IDLE || arm_q == DBNSC_ARMED) && wr_sync && !next_wr_val
            |=> arm_q == DBNSC_PRIMED)
        else $error("zero write did not prime");

    a_arm_no_skip: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q == DBNSC_IDLE && wr_sync && next_wr_val |=> !sync_armed)
        else $error("armed without zero write");

    a_armed_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q == DBNSC_ARMED && !sysref_rise && !wr_sync |=> sync_armed)
        else $error("arm dropped without sysref");

    a_armed_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q == DBNSC_ARMED && sysref_rise && !wr_sync |=> !sync_armed)
        else $error("arm kept after sysref init");

    a_armed_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sync_armed |-> arm_q == DBNSC_ARMED)
        else $error("armed flag without armed state");

    a_arm_legal: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q inside {DBNSC_IDLE, DBNSC_PRIMED, DBNSC_ARMED})
        else $error("arm state illegal");

    // phase init only from a known cause
    a_init_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && nco_phase_init |-> $past(arm_q == DBNSC_ARMED && sysref_rise)
            || $past(sync_q[BIT_SYNC_ILA] && lmfc_ila_start))
        else $error("spurious phase init");

    a_ila_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q != DBNSC_ARMED && !sync_q[BIT_SYNC_ILA] |=> !nco_phase_init)
        else $error("init while neither source enabled");

    // sysref path: two flops, then an edge detector
    a_sync_pipe: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && !$past(sys_rst, 2) |-> sysref_s == $past(sysref_pin, 2))
        else $error("sysref synchroniser latency wrong");

    a_prev_track: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> sysref_prev_q == $past(sysref_s))
        else $error("sysref edge history wrong");

    c_arm: cover property (@(posedge ref_clk) arm_q == DBNSC_ARMED);
    c_sysref_init: cover property (@(posedge ref_clk) arm_q == DBNSC_ARMED && sysref_rise);
    c_ila_init: cover property (@(posedge ref_clk) sync_q[BIT_SYNC_ILA] && lmfc_ila_start);
    c_swap: cover property (@(posedge ref_clk) routing_q[1:0] == 2'b01);
endmodule // dbnsc_ctrl

// file: verif/dbnsc_far_end.sv
`timescale 1ns/1ps
// Purpose: sysref source and link receiver stand-in
// Assumes: fire and ila_req are one-cycle requests from the bench
// Notes: sysref idles low, edges placed off the clock edge
module dbnsc_far_end (
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic ila_req,
    output logic sysref_pin,
    output logic lmfc_ila_start
);
    initial begin
        sysref_pin = 1'b0;
        lmfc_ila_start = 1'b0;
    end
    always @(posedge ref_clk) begin
        lmfc_ila_start <= ila_req;
        if (fire) begin
            #7 sysref_pin = 1'b1;
            repeat (4) @(posedge ref_clk);
            #7 sysref_pin = 1'b0;
        end
    end
endmodule // dbnsc_far_end

// file: verif/dbnsc_ctrl_tb.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for routing, divisor and nco_phase_sync_control control
// Assumes: register port strobes one cycle long
// Notes: init pulses counted by a counter that steps only on cycles with nco_phase_init high
module dbnsc_ctrl_tb;
    import dbnsc_pkg::*;
    logic ref_clk, sys_rst, reg_wr, reg_rd, converter_a_powerdown, converter_b_powerdown;
    logic fire, ila_req, sysref_pin, lmfc_ila_start, path_a_powerdown, path_b_powerdown;
    logic nco_phase_init, sync_armed;
    logic [11:0] reg_addr, conv_a_data, conv_b_data, path_a_data, path_b_data;
    logic [7:0] reg_wdata, reg_rdata;
    logic [15:0] rational_nco_divisor;
    int fail_count = 0, tests_run = 0, init_cnt = 0, n;
    dbnsc_ctrl #(.SAMPLE_W(12)) dbnsc_ctrl_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .conv_a_data, .conv_b_data, .converter_a_powerdown, .converter_b_powerdown,
        .sysref_pin, .lmfc_ila_start, .path_a_data, .path_b_data, .path_a_powerdown, .path_b_powerdown,
        .rational_nco_divisor, .nco_phase_init, .sync_armed);
    dbnsc_far_end dbnsc_far_end_inst (.ref_clk, .fire, .ila_req, .sysref_pin, .lmfc_ila_start);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (nco_phase_init === 1'b1) init_cnt <= init_cnt + 1;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic pulse(input logic sys, output int cnt);
        int c0;
        c0 = init_cnt;
        @(posedge ref_clk);
        fire <= sys;
        ila_req <= ~sys;
        @(posedge ref_clk);
        fire <= 1'b0;
        ila_req <= 1'b0;
        repeat (12) @(posedge ref_clk);
        cnt = init_cnt - c0;
    endtask
    task automatic t_reset;
        rd_chk(ADDR_ROUTING, 8'h02);
        rd_chk(ADDR_RDIV_LO, 8'h00);
        rd_chk(ADDR_SYNC, 8'h02);
        rd_chk(12'h21a, 8'h00);
        wr(ADDR_RDIV_LO, 8'h34);
        wr(ADDR_RDIV_HI, 8'hc2);
        @(posedge ref_clk);
        #1 check(rational_nco_divisor, 16'hc234);
        rd_chk(ADDR_RDIV_HI, 8'hc2);
        $display("t_reset done");
    endtask
    task automatic t_route;
        conv_a_data <= 12'h5a1;
        conv_b_data <= 12'ha5e;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_ROUTING, 8'ha8 | 8'(i));
            rd_chk(ADDR_ROUTING, 8'ha8 | 8'(i));
            check(path_a_data, i[0] ? 12'ha5e : 12'h5a1);
            check(path_b_data, i[1] ? 12'ha5e : 12'h5a1);
            for (int j = 0; j < 4; j++) begin
                converter_a_powerdown <= j[0];
                converter_b_powerdown <= j[1];
                repeat (2) @(posedge ref_clk);
                #1 check(path_a_powerdown, i[0] ? j[1] : j[0]);
                check(path_b_powerdown, i[1] ? j[1] : j[0]);
            end
        end
        wr(ADDR_ROUTING, 8'h02);
        $display("t_route done");
    endtask
    task automatic t_arm;
        wr(ADDR_SYNC, 8'h03);
        check(sync_armed, 1'b0);
        pulse(1'b0, n);
        check(n, 1);
        wr(ADDR_SYNC, 8'h00);
        pulse(1'b0, n);
        check(n, 0);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_SYNC, 8'h00);
            wr(ADDR_SYNC, 8'h01);
            check(sync_armed, 1'b1);
            pulse(1'b1, n);
            check(n, 1);
            check(sync_armed, 1'b0);
            pulse(1'b1, n);
            check(n, 0);
        end
        $display("t_arm done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, fire, ila_req} = 5'h10;
        {converter_a_powerdown, converter_b_powerdown} = 2'h0;
        {reg_addr, reg_wdata, conv_a_data, conv_b_data} = '0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_route();
        t_arm();
        give_verdict();
    end
endmodule // dbnsc_ctrl_tb
